/* logic/tafcs_pkg.sv */
// Constants and types for the touch converter filter and channel select block
//
// Operation
// R1 - Code 101 measures pressure sample one, result to offset 0x0A.
// R2 - Code 100 measures pressure sample two, result to offset 0x0B.
// R3 - Code 001 does one diode temperature conversion into offset 0x0D; the code takes as many conversions as the filter settings select.
// R4 - Temperature conversions always use longest acquisition, 16 units.
// R5 - Temperature limits compare against raw value held at offset 0x0D; the code passes on the filtered result stored there.
// R6 - Median filter keeps measurements sorted smallest to largest.
// R7 - Bits 6:5 of control two pick median: off, 4, 8, 16.
// R8 - Bits 8:7 of control two pick averaging: 2, 4, 8, 16.
// R9 - Only the final averaged value ever reaches a result register.
// R10 - Both filter fields zero: exactly one measurement is transferred.
// R11 - Host keeps median window at least as large as averaging window.
// R12 - Equal median and average counts: no sorting, plain average.
// R13 - Median larger than average A: average the A middle sorted entries.
// R14 - Each sorted insertion costs about 2 us, lengthening update time.
// R15 - Channel select field sits in bits 14:12 of control one, 0x01.
// R16 - Code 011 converts spare analog input into shared register 0x0C.
// R17 - Code 010 measures the supply monitor on the multifunction pin.
// R18 - Bit 13 of control two turns the pin into digital I/O.
// R19 - Supply monitor results share result register 0x0C.
// R20 - Twelve-bit results sit right-aligned, upper four bits read zero.
`default_nettype none

package tafcs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONV_CTRL = 8'h01;
  localparam logic [7:0] ADDR_FILT_PIN = 8'h02;
  localparam logic [7:0] ADDR_PRESS_ONE = 8'h0A;
  localparam logic [7:0] ADDR_PRESS_TWO = 8'h0B;
  localparam logic [7:0] ADDR_SPARE = 8'h0C;
  localparam logic [7:0] ADDR_TEMP = 8'h0D;
  localparam int REG_W = 16;
  localparam int RESULT_W = 12;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CHAN_LSB = 12;
  localparam int ACQ_LSB = 8;
  localparam int MED_LSB = 5;
  localparam int AVG_LSB = 7;
  localparam int PIN_GPIO_BIT = 13;

  // ----------------------------------------------------------------
  // Channel codes and acquisition settings
  // ----------------------------------------------------------------
  localparam logic [2:0] CHAN_TEMP = 3'h1;
  localparam logic [2:0] CHAN_SUPPLY = 3'h2;
  localparam logic [2:0] CHAN_SPARE = 3'h3;
  localparam logic [2:0] CHAN_PRESS_TWO = 3'h4;
  localparam logic [2:0] CHAN_PRESS_ONE = 3'h5;
  localparam logic [1:0] ACQ_LONGEST = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  // Sorted insertion time is in microseconds
  localparam int T_SORT_US = 2;
  localparam int T_SORT_PS = T_SORT_US * 1000000;
  localparam int SORT_CYCLES = (T_SORT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } tafcs_reg_req_t;

  typedef struct packed {
    logic [2:0] chan;
    logic [1:0] acq;
  } tafcs_conv_cfg_t;

  typedef enum {ST_IDLE, ST_CONV, ST_SORT, ST_SUM, ST_STORE} tafcs_state_t;

endpackage : tafcs_pkg

`default_nettype wire

/* logic/tafcs_rank_array.sv */
// Sorted insertion array holding the median filter window
`default_nettype none
`timescale 1ns/1ps

module tafcs_rank_array #(
  parameter int DEPTH = 16,
  parameter int W = 12
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_clear,
  input wire logic i_insert,
  input wire logic [W-1:0] i_sample,
  // Sorted contents, entry 0 smallest
  output logic [W-1:0] o_entry [DEPTH]
);

  localparam logic [W-1:0] FILL = {W{1'b1}};

  logic [W-1:0] entry_q [DEPTH];

  // ----------------------------------------------------------------
  // Per-entry shift-insert cell
  // ----------------------------------------------------------------
  // Empty slots hold the maximum so any sample below the maximum lands before them
  for (genvar i = 0; i < DEPTH; i++) begin : g_cell
    wire logic below = (i_sample < entry_q[i]);
    wire logic left_big;
    wire logic [W-1:0] shift_in;
    if (i == 0) begin : g_first
      assign left_big = 1'b0;
      assign shift_in = i_sample;
    end else begin : g_rest
      assign left_big = (i_sample < entry_q[i-1]);
      assign shift_in = left_big ? entry_q[i-1] : i_sample;
    end
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        entry_q[i] <= FILL;
      end else if (i_clear) begin
        entry_q[i] <= FILL;
      end else if (i_insert && below) begin
        entry_q[i] <= shift_in; // see R6
      end
    end
    assign o_entry[i] = entry_q[i];
  end

endmodule // tafcs_rank_array

`default_nettype wire

/* logic/tafcs_filter_chan.sv */
// Channel select, rank and mean filter and result registers
`default_nettype none
`timescale 1ns/1ps

module tafcs_filter_chan #(
  parameter int MAX_WIN = 16,
  parameter int SORT_WAIT = tafcs_pkg::SORT_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Register port
  input wire tafcs_pkg::tafcs_reg_req_t i_reg,
  output logic [tafcs_pkg::REG_W-1:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Sequence control
  input wire logic i_start,
  output logic o_busy,
  output logic o_result_done,
  // Converter handshake
  output logic o_conv_req,
  output tafcs_pkg::tafcs_conv_cfg_t o_conv_cfg,
  input wire logic i_conv_valid,
  input wire logic [tafcs_pkg::RESULT_W-1:0] i_conv_data,
  // Pin mode and limit compare source
  output logic o_pin_gpio_mode,
  output logic [tafcs_pkg::REG_W-1:0] o_temp_limit_value
);
  import tafcs_pkg::*;

  localparam int SUM_W = RESULT_W + 4;
  localparam int CNT_W = $clog2(MAX_WIN + 1);
  localparam int IDX_W = $clog2(MAX_WIN);
  localparam int WAIT_W = $clog2(SORT_WAIT + 1);
  localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(SORT_WAIT - 1);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  tafcs_state_t state_q, state_d;
  logic [REG_W-1:0] conv_ctrl_q;
  logic [REG_W-1:0] filt_pin_q;
  logic [REG_W-1:0] press_one_q;
  logic [REG_W-1:0] press_two_q;
  logic [REG_W-1:0] spare_q;
  logic [REG_W-1:0] temp_q;
  logic [REG_W-1:0] rdata_q;
  logic rvalid_q;
  logic done_q;
  tafcs_conv_cfg_t cfg_q;
  logic [CNT_W-1:0] cnt_q;
  logic [IDX_W-1:0] idx_q;
  logic [WAIT_W-1:0] wait_q;
  logic [SUM_W-1:0] sum_q;
  logic sort_q;
  logic [CNT_W-1:0] total_q;
  logic [CNT_W-1:0] avg_n_q;
  logic [2:0] shift_q;
  logic [IDX_W-1:0] lo_q;
  logic [RESULT_W-1:0] rank [MAX_WIN];

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire logic [2:0] chan_sel = conv_ctrl_q[CHAN_LSB +: 3]; // see R15
  wire logic [1:0] acq_sel = conv_ctrl_q[ACQ_LSB +: 2];
  wire logic [1:0] med_code = filt_pin_q[MED_LSB +: 2]; // see R7
  wire logic [1:0] avg_code = filt_pin_q[AVG_LSB +: 2]; // see R8
  wire logic gpio_mode = filt_pin_q[PIN_GPIO_BIT]; // see R18

  // Window sizes as powers of two
  wire logic [CNT_W-1:0] med_n = CNT_W'(2) << med_code;
  wire logic [CNT_W-1:0] avg_n = CNT_W'(2) << avg_code;
  wire logic single = (med_code == 2'h0) && (avg_code == 2'h0); // see R10
  wire logic sort_sel = (med_code != 2'h0) && (med_code > avg_code); // see R12
  wire logic [CNT_W-1:0] total_n = single ? CNT_W'(1) : (sort_sel ? med_n : avg_n);
  wire logic [CNT_W-1:0] avg_use = single ? CNT_W'(1) : avg_n;
  wire logic [2:0] shift_n = single ? 3'h0 : (3'h1 + {1'b0, avg_code});
  wire logic [CNT_W-1:0] lo_n = (med_n - avg_n) >> 1; // see R13

  // Only mapped channels start; pin channels refused in digital mode
  wire logic pin_chan = (chan_sel == CHAN_SPARE) || (chan_sel == CHAN_SUPPLY);
  wire logic chan_ok = (chan_sel == CHAN_TEMP) || (chan_sel == CHAN_PRESS_ONE) ||
                       (chan_sel == CHAN_PRESS_TWO) || (pin_chan && !gpio_mode);
  wire logic go = i_start && (state_q == ST_IDLE) && chan_ok;

  // Temperature forces the longest acquisition
  wire logic [1:0] acq_use = (chan_sel == CHAN_TEMP) ? ACQ_LONGEST : acq_sel; // see R4

  // ----------------------------------------------------------------
  // Sample flow
  // ----------------------------------------------------------------
  wire logic take = (state_q == ST_CONV) && i_conv_valid;
  wire logic last_sample = (cnt_q == total_q - CNT_W'(1));
  wire logic sort_done = (state_q == ST_SORT) && (wait_q == WAIT_LAST);
  wire logic last_sum = (state_q == ST_SUM) && (cnt_q == avg_n_q - CNT_W'(1));
  wire logic [SUM_W-1:0] add_val = (state_q == ST_SUM) ? SUM_W'(rank[idx_q]) : SUM_W'(i_conv_data);
  wire logic add_en = (take && !sort_q) || (state_q == ST_SUM);
  wire logic [SUM_W-1:0] sum_next = sum_q + add_val;
  wire logic [SUM_W-1:0] mean_full = sum_q >> shift_q;
  wire logic [REG_W-1:0] result = {{(REG_W-RESULT_W){1'b0}}, mean_full[RESULT_W-1:0]}; // see R20

  // Median window storage
  tafcs_rank_array #(
    .DEPTH(MAX_WIN),
    .W(RESULT_W)
  ) u_rank (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_clear(go),
    .i_insert(take && sort_q), // see R6
    .i_sample(i_conv_data),
    .o_entry(rank)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state of the filter sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (go) begin
          state_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (i_conv_valid) begin
          if (sort_q) begin
            state_d = ST_SORT; // see R14
          end else if (last_sample) begin
            state_d = ST_STORE;
          end
        end
      end
      ST_SORT: begin
        if (sort_done) begin
          state_d = last_sample ? ST_SUM : ST_CONV;
        end
      end
      ST_SUM: begin
        if (last_sum) begin
          state_d = ST_STORE;
        end
      end
      ST_STORE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Latch window setup at sequence start
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_q <= '0;
      sort_q <= 1'b0;
      total_q <= '0;
      avg_n_q <= '0;
      shift_q <= 3'h0;
      lo_q <= '0;
    end else if (go) begin
      cfg_q <= '{chan: chan_sel, acq: acq_use};
      sort_q <= sort_sel;
      total_q <= total_n;
      avg_n_q <= avg_use;
      shift_q <= shift_n;
      lo_q <= lo_n[IDX_W-1:0];
    end
  end

  // Sample and summation counter, reused in the sum phase
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (go || (sort_done && last_sample)) begin
      cnt_q <= '0;
    end else if ((take && !sort_q) || sort_done || (state_q == ST_SUM)) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Index into the middle of the sorted window
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_q <= '0;
    end else if (sort_done && last_sample) begin
      idx_q <= lo_q; // see R13
    end else if (state_q == ST_SUM) begin
      idx_q <= idx_q + IDX_W'(1);
    end
  end

  // Insertion delay per sorted sample
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_q <= '0;
    end else if (state_q == ST_SORT) begin
      wait_q <= wait_q + WAIT_W'(1); // see R14
    end else begin
      wait_q <= '0;
    end
  end

  // Running sum, never visible in the map
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sum_q <= '0;
    end else if (go) begin
      sum_q <= '0;
    end else if (add_en) begin
      sum_q <= sum_next; // see R9
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  wire logic wr_ctrl = i_reg.wr && (i_reg.addr == ADDR_CONV_CTRL);
  wire logic wr_filt = i_reg.wr && (i_reg.addr == ADDR_FILT_PIN);
  wire logic store = (state_q == ST_STORE);

  // Host-writable control
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      conv_ctrl_q <= REG_RESET;
      filt_pin_q <= REG_RESET;
    end else begin
      if (wr_ctrl) begin
        conv_ctrl_q <= i_reg.wdata;
      end
      if (wr_filt) begin
        filt_pin_q <= i_reg.wdata;
      end
    end
  end

  // Result routing by channel, final value only
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      press_one_q <= REG_RESET;
      press_two_q <= REG_RESET;
      spare_q <= REG_RESET;
      temp_q <= REG_RESET;
    end else if (store) begin
      case (cfg_q.chan)
        CHAN_PRESS_ONE: press_one_q <= result; // see R1
        CHAN_PRESS_TWO: press_two_q <= result; // see R2
        CHAN_TEMP: temp_q <= result; // see R3
        CHAN_SPARE: spare_q <= result; // see R16
        CHAN_SUPPLY: spare_q <= result; // see R17 R19
        default: ;
      endcase
    end
  end

  // Read mux, unmapped offsets return zero
  wire logic [REG_W-1:0] rd_mux =
    (i_reg.addr == ADDR_CONV_CTRL) ? conv_ctrl_q :
    (i_reg.addr == ADDR_FILT_PIN) ? filt_pin_q :
    (i_reg.addr == ADDR_PRESS_ONE) ? press_one_q :
    (i_reg.addr == ADDR_PRESS_TWO) ? press_two_q :
    (i_reg.addr == ADDR_SPARE) ? spare_q :
    (i_reg.addr == ADDR_TEMP) ? temp_q : REG_RESET;

  // Read data and completion flags
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= REG_RESET;
      rvalid_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      rvalid_q <= i_reg.rd;
      done_q <= store;
      if (i_reg.rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_reg_rdata = rdata_q;
  assign o_reg_rvalid = rvalid_q;
  assign o_busy = (state_q != ST_IDLE);
  assign o_result_done = done_q;
  assign o_conv_req = (state_q == ST_CONV);
  assign o_conv_cfg = cfg_q;
  assign o_pin_gpio_mode = gpio_mode; // see R18
  assign o_temp_limit_value = temp_q; // see R5

endmodule // tafcs_filter_chan

`default_nettype wire

/* dv/tafcs_filter_chan_assertions.sv */
// Port-level assertions for the filter and channel select block
`timescale 1ns/1ps
`default_nettype none
module tafcs_filter_chan_assertions import tafcs_pkg::*; #(
  parameter int MAX_WIN = 16,
  parameter int SORT_WAIT = 500
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Register port
  input wire tafcs_pkg::tafcs_reg_req_t i_reg,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  // Sequence and converter
  input wire logic i_start,
  input wire logic o_busy,
  input wire logic o_result_done,
  input wire logic o_conv_req,
  input wire tafcs_pkg::tafcs_conv_cfg_t o_conv_cfg,
  input wire logic i_conv_valid,
  input wire logic [11:0] i_conv_data,
  // Pin mode and limit source
  input wire logic o_pin_gpio_mode,
  input wire logic [15:0] o_temp_limit_value
);
  // ------
  // Decode
  // ------
  // Address classes on the register port
  wire logic map_hit = i_reg.addr inside {ADDR_CONV_CTRL, ADDR_FILT_PIN, [ADDR_PRESS_ONE:ADDR_TEMP]};
  wire logic res_hit = i_reg.addr inside {[ADDR_PRESS_ONE:ADDR_TEMP]};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Accepted start, then a one-cycle done
  sequence s_start_taken;
    !o_busy && i_start ##1 o_busy;
  endsequence
  sequence s_done_pulse;
    o_result_done ##1 !o_result_done;
  endsequence
  // ------
  // Assertions
  // ------
  a_rd_answer: assert property (i_reg.rd |=> o_reg_rvalid)
    else $error("read not answered");
  a_unmapped_zero: assert property (i_reg.rd && !map_hit |=> o_reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_result_msb_zero: assert property (i_reg.rd && res_hit |=> o_reg_rdata[15:12] == 4'h0)
    else $error("result upper bits set");
  a_temp_read_same: assert property (i_reg.rd && i_reg.addr == ADDR_TEMP |=> o_reg_rdata == $past(o_temp_limit_value))
    else $error("limit source differs from temperature register");
  a_temp_hold: assert property (!o_result_done |-> $stable(o_temp_limit_value))
    else $error("temperature register moved without done");
  a_temp_acq_long: assert property (o_conv_req && o_conv_cfg.chan == CHAN_TEMP |-> o_conv_cfg.acq == ACQ_LONGEST)
    else $error("temperature acquisition not longest");
  a_chan_legal: assert property (o_conv_req |-> o_conv_cfg.chan inside {[CHAN_TEMP:CHAN_PRESS_ONE]})
    else $error("request on unknown channel");
  a_gpio_follow: assert property (i_reg.wr && i_reg.addr == ADDR_FILT_PIN |=> o_pin_gpio_mode == $past(i_reg.wdata[13]))
    else $error("pin mode not from written bit");
  a_start_req: assert property (s_start_taken |-> o_conv_req)
    else $error("start without conversion request");
  a_done_end: assert property ($fell(o_busy) |-> s_done_pulse)
    else $error("sequence end without single done");
endmodule // tafcs_filter_chan_assertions

bind tafcs_filter_chan tafcs_filter_chan_assertions #(.MAX_WIN(MAX_WIN), .SORT_WAIT(SORT_WAIT))
  u_chk (.i_core_clk, .i_rst_n, .i_reg, .o_reg_rdata, .o_reg_rvalid, .i_start, .o_busy, .o_result_done,
  .o_conv_req, .o_conv_cfg, .i_conv_valid, .i_conv_data, .o_pin_gpio_mode, .o_temp_limit_value);
`default_nettype wire

/* dv/tafcs_conv_model.sv */
// Behavioural converter answering the block's conversion requests
`timescale 1ns/1ps
`default_nettype none
module tafcs_conv_model (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Bench control
  input wire logic i_rewind,
  input wire logic [3:0] i_lat,
  input wire logic [11:0] i_samples [16],
  // Converter handshake
  input wire logic i_conv_req,
  output logic o_conv_valid,
  output logic [11:0] o_conv_data
);
  logic [3:0] idx_q;
  logic [3:0] wait_q;
  // ------
  // Answer
  // ------
  // One sample per request after i_lat cycles; data scrambled off the strobe
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_q <= 4'h0;
      wait_q <= 4'h0;
      o_conv_valid <= 1'b0;
      o_conv_data <= 12'hA5A;
    end else if (o_conv_valid) begin
      o_conv_valid <= 1'b0;
      o_conv_data <= ~o_conv_data;
      wait_q <= 4'h0;
    end else if (i_conv_req && wait_q >= i_lat) begin
      o_conv_valid <= 1'b1;
      o_conv_data <= i_samples[idx_q];
      idx_q <= idx_q + 4'h1;
    end else begin
      o_conv_data <= ~o_conv_data;
      wait_q <= wait_q + {3'h0, i_conv_req};
    end
    if (i_rst_n && i_rewind) idx_q <= 4'h0;
  end
endmodule // tafcs_conv_model
`default_nettype wire

/* dv/tb_tafcs_filter_chan.sv */
// Self-checking bench for the filter and channel select block
`timescale 1ns/1ps
`default_nettype none
module tb_tafcs_filter_chan;
  import tafcs_pkg::*;
  localparam int SW = 3;
  logic i_core_clk = 1'b0;
  logic i_rst_n;
  logic i_start;
  logic rewind;
  logic [3:0] lat;
  logic [11:0] smp [16];
  tafcs_reg_req_t i_reg;
  tafcs_conv_cfg_t cfg;
  logic [15:0] rdata;
  logic [15:0] tlim;
  logic [11:0] conv_data;
  logic rvalid;
  logic busy;
  logic done;
  logic conv_req;
  logic conv_valid;
  logic gpio;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  // Block under test with a shortened sort wait
  tafcs_filter_chan #(.SORT_WAIT(SW)) u_tafcs_filter_chan (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_reg(i_reg), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_start(i_start), .o_busy(busy),
    .o_result_done(done), .o_conv_req(conv_req), .o_conv_cfg(cfg), .i_conv_valid(conv_valid),
    .i_conv_data(conv_data), .o_pin_gpio_mode(gpio), .o_temp_limit_value(tlim));
  // Converter on the far side
  tafcs_conv_model u_tafcs_conv_model (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_rewind(rewind),
    .i_lat(lat), .i_samples(smp), .i_conv_req(conv_req), .o_conv_valid(conv_valid), .o_conv_data(conv_data));
  // Clock and hang guard
  initial begin
    forever #2 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  // ------
  // Helpers
  // ------
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic final_report();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    i_reg = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_core_clk);
    i_reg = '0;
    @(negedge i_core_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    i_reg = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge i_core_clk);
    chk("read valid", 16'h0001, {15'h0000, rvalid});
    chk($sformatf("reg %h", a), e, rdata);
    i_reg = '0;
    @(negedge i_core_clk);
  endtask
  // Sort the window, average the middle entries, truncate
  function automatic logic [11:0] exp_of(input logic [1:0] mc, input logic [1:0] ac);
    int a;
    int m;
    int s;
    logic [11:0] v [16];
    logic [11:0] x;
    a = (mc == 2'h0 && ac == 2'h0) ? 1 : 2 << ac;
    m = (mc == 2'h0) ? a : 2 << mc;
    v = smp;
    for (int i = 0; i < m; i++) begin
      for (int j = i + 1; j < m; j++) begin
        if (v[j] < v[i]) begin
          x = v[i];
          v[i] = v[j];
          v[j] = x;
        end
      end
    end
    s = 0;
    for (int i = 0; i < a; i++) s += v[(m - a) / 2 + i];
    return 12'(s / a);
  endfunction
  // One filtered result on a channel, checked in its register
  task automatic run(input logic [2:0] ch, input logic [1:0] mc, input logic [1:0] ac, input logic [7:0] ra);
    int t;
    logic [1:0] acq;
    acq = (ch == CHAN_TEMP) ? ACQ_LONGEST : 2'h1;
    reg_wr(ADDR_FILT_PIN, {7'h00, ac, mc, 5'h00});
    reg_wr(ADDR_CONV_CTRL, {1'b0, ch, 4'h1, 8'h00});
    rewind = 1'b1;
    i_start = 1'b1;
    @(negedge i_core_clk);
    rewind = 1'b0;
    i_start = 1'b0;
    chk("busy", 16'h0001, {15'h0000, busy});
    t = 0;
    while (done !== 1'b1 && t < 3000) begin
      if (conv_req === 1'b1) chk("conv cfg", {11'h000, ch, acq}, {11'h000, cfg});
      @(negedge i_core_clk);
      t++;
    end
    chk("done", 16'h0001, {15'h0000, done});
    if (mc > ac) chk("sort time", 16'h0001, {15'h0000, t >= (2 << mc) * SW});
    @(negedge i_core_clk);
    chk("done once", 16'h0000, {15'h0000, done});
    rd_chk(ra, {4'h0, exp_of(mc, ac)});
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_regs();
    logic [7:0] ads [7];
    ads = '{ADDR_CONV_CTRL, ADDR_FILT_PIN, ADDR_PRESS_ONE, ADDR_PRESS_TWO, ADDR_SPARE, ADDR_TEMP, 8'h07};
    foreach (ads[i]) rd_chk(ads[i], REG_RESET);
    reg_wr(ADDR_CONV_CTRL, 16'h5A5A);
    rd_chk(ADDR_CONV_CTRL, 16'h5A5A);
    reg_wr(ADDR_FILT_PIN, 16'h01E0);
    rd_chk(ADDR_FILT_PIN, 16'h01E0);
    reg_wr(ADDR_PRESS_ONE, 16'hFFFF);
    rd_chk(ADDR_PRESS_ONE, 16'h0000);
  endtask
  task automatic t_channels();
    logic [2:0] chs [5];
    logic [7:0] ras [5];
    chs = '{CHAN_PRESS_ONE, CHAN_PRESS_TWO, CHAN_TEMP, CHAN_SPARE, CHAN_SUPPLY};
    ras = '{ADDR_PRESS_ONE, ADDR_PRESS_TWO, ADDR_TEMP, ADDR_SPARE, ADDR_SPARE};
    for (int i = 0; i < 5; i++) begin
      smp[0] = 12'hF00 + 12'(i);
      lat = 4'(i);
      run(chs[i], 2'h0, 2'h0, ras[i]);
    end
    chk("limit source", 16'h0F02, tlim);
    rd_chk(ADDR_PRESS_ONE, 16'h0F00);
  endtask
  task automatic t_filters();
    logic [1:0] mcs [6];
    logic [1:0] acs [6];
    mcs = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h3, 2'h1};
    acs = '{2'h1, 2'h0, 2'h2, 2'h1, 2'h3, 2'h0};
    smp = '{12'h100, 12'hFFF, 12'h120, 12'h000, 12'h110, 12'h130, 12'h105, 12'h800,
            12'h115, 12'h125, 12'h0FF, 12'h10A, 12'h400, 12'h001, 12'h11A, 12'h12A};
    for (int i = 0; i < 6; i++) begin
      lat = 4'(i);
      run(CHAN_PRESS_TWO, mcs[i], acs[i], ADDR_PRESS_TWO);
    end
  endtask
  // Start on a channel that must be refused: no sequence begins
  task automatic refused(input logic [2:0] ch);
    reg_wr(ADDR_CONV_CTRL, {1'b0, ch, 12'h100});
    i_start = 1'b1;
    @(negedge i_core_clk);
    i_start = 1'b0;
    repeat (3) @(negedge i_core_clk);
    chk("busy", 16'h0000, {15'h0000, busy});
  endtask
  task automatic t_pin_mode();
    reg_wr(ADDR_FILT_PIN, 16'h2000);
    chk("pin mode", 16'h0001, {15'h0000, gpio});
    refused(CHAN_SPARE);
    refused(CHAN_SUPPLY);
    reg_wr(ADDR_FILT_PIN, 16'h0000);
    chk("pin mode", 16'h0000, {15'h0000, gpio});
    refused(3'h0);
    refused(3'h6);
    refused(3'h7);
  endtask
  // Reset, then the scenarios
  initial begin
    i_rst_n = 1'b0;
    i_start = 1'b0;
    rewind = 1'b0;
    lat = 4'h0;
    i_reg = '0;
    foreach (smp[i]) smp[i] = 12'h000;
    repeat (5) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    t_regs();
    t_channels();
    t_filters();
    t_pin_mode();
    final_report();
  end
endmodule // tb_tafcs_filter_chan
`default_nettype wire
